// ===== dsfsg_pkg.sv
// constants and carrier types for the ds1 format and sync generator
package dsfsg_pkg;
  localparam int CORE_CLK_KHZ = 200000;
  localparam int BIT_CLK_KHZ = 1544;
  localparam int ACC_W = 18;
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CORE_CLK_KHZ);
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(BIT_CLK_KHZ);
  localparam logic [ACC_W-1:0] ACC_RESET = 18'h00000;
  localparam int CYC_PER_BIT_MIN = CORE_CLK_KHZ / BIT_CLK_KHZ;
  localparam int CYC_PER_BIT_MAX = (CORE_CLK_KHZ + BIT_CLK_KHZ - 1) / BIT_CLK_KHZ;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [7:0] FRAME_LAST_BIT = 8'hC0;
  localparam logic [7:0] BIT_CNT_RESET = 8'h00;
  localparam logic [2:0] SLOT_LOAD_PHASE = 3'h1;
  localparam logic SYNC_ACTIVE = 1'b1;

  typedef struct packed {
    logic data;
    logic mark_pos;
    logic mark_neg;
    logic frame_start;
  } dsfsg_line_s;
endpackage : dsfsg_pkg

// ===== dsfsg_framer.sv
// ds1 serializer with frame sync, ami split and its input fifo
`timescale 1ns/1ps

module dsfsg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  logic [PW:0] next_wr_ptr;
  logic [PW:0] next_rd_ptr;
  logic push;
  logic pop;

  always_comb begin
    out_valid = wr_ptr != rd_ptr;
    in_ready = (wr_ptr[PW-1:0] != rd_ptr[PW-1:0]) || (wr_ptr[PW] == rd_ptr[PW]);
    out_data = mem[rd_ptr[PW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      if (push) begin
        mem[wr_ptr[PW-1:0]] <= in_data;
      end
    end
  end
endmodule : dsfsg_fifo

module dsfsg_framer (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // payload bytes
  input wire logic [dsfsg_pkg::DATA_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // framing bit for the next frame, same clock
  input wire logic frame_bit,
  // external frame sync pin, active high
  input wire logic sync_pin,
  // line-length switch and shape select toward line interface
  input wire logic [3:0] line_len_bcd,
  output logic [3:0] shape_sel,
  // logic-level stream and ami marks toward line interface
  output dsfsg_pkg::dsfsg_line_s line_out,
  output logic underrun
);
  logic [dsfsg_pkg::ACC_W-1:0] acc;
  logic [dsfsg_pkg::ACC_W-1:0] next_acc;
  logic bit_tick;
  logic tick_en;
  logic sync_q1;
  logic sync_q2;
  logic sync_q3;
  logic sync_release;
  logic pending;
  logic next_pending;
  logic [7:0] bit_cnt;
  logic [7:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic mark_pol;
  logic next_mark_pol;
  dsfsg_pkg::dsfsg_line_s next_line;
  logic next_underrun;
  logic [dsfsg_pkg::DATA_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic [7:0] byte_now;
  logic bit_now;
  logic [3:0] len_q1;

  dsfsg_fifo #(
    .WIDTH(dsfsg_pkg::DATA_W),
    .DEPTH(dsfsg_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .in_data(in_data),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // fractional bit-rate divider: 200 MHz is no integer multiple of the line rate
  always_comb begin
    bit_tick = (acc + dsfsg_pkg::ACC_STEP) >= dsfsg_pkg::ACC_MOD;
    next_acc = bit_tick ? acc + dsfsg_pkg::ACC_STEP - dsfsg_pkg::ACC_MOD
                        : acc + dsfsg_pkg::ACC_STEP;
    tick_en = bit_tick && ce;
  end

  // sync pin crosses in via two flops; the edge only looks at later stages
  always_comb begin
    sync_release = (sync_q2 != dsfsg_pkg::SYNC_ACTIVE) && (sync_q3 == dsfsg_pkg::SYNC_ACTIVE);
    // a release landing on the applying tick keeps the request
    next_pending = sync_release || (pending && !bit_tick);
  end

  // serializer, frame counter, ami polarity
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_mark_pol = mark_pol;
    next_line = line_out;
    next_underrun = 1'b0;
    fifo_pop = 1'b0;
    byte_now = 8'h00;
    bit_now = 1'b0;
    next_line.frame_start = line_out.frame_start && !bit_tick;
    if (bit_tick) begin
      if (pending || bit_cnt == dsfsg_pkg::FRAME_LAST_BIT) begin
        next_bit_cnt = dsfsg_pkg::BIT_CNT_RESET;
      end else begin
        next_bit_cnt = bit_cnt + 8'h01;
      end
      if (next_bit_cnt == dsfsg_pkg::BIT_CNT_RESET) begin
        bit_now = frame_bit;
        next_line.frame_start = 1'b1;
      end else if (next_bit_cnt[2:0] == dsfsg_pkg::SLOT_LOAD_PHASE) begin
        // empty fifo sends an all-zero channel rather than stalling the line
        byte_now = fifo_valid ? fifo_data : 8'h00;
        fifo_pop = fifo_valid && ce;
        next_underrun = !fifo_valid;
        bit_now = byte_now[7];
        next_shreg = {byte_now[6:0], 1'b0};
      end else begin
        bit_now = shreg[7];
        next_shreg = {shreg[6:0], 1'b0};
      end
      next_line.data = bit_now;
      next_line.mark_pos = bit_now && !mark_pol;
      next_line.mark_neg = bit_now && mark_pol;
      if (bit_now) begin
        next_mark_pol = !mark_pol;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      acc <= dsfsg_pkg::ACC_RESET;
      sync_q1 <= 1'b0;
      sync_q2 <= 1'b0;
      sync_q3 <= 1'b0;
      pending <= 1'b0;
      bit_cnt <= dsfsg_pkg::BIT_CNT_RESET;
      shreg <= 8'h00;
      mark_pol <= 1'b0;
      line_out <= '0;
      underrun <= 1'b0;
      len_q1 <= 4'h0;
      shape_sel <= 4'h0;
    end else if (ce) begin
      acc <= next_acc;
      sync_q1 <= sync_pin;
      sync_q2 <= sync_q1;
      sync_q3 <= sync_q2;
      pending <= next_pending;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      mark_pol <= next_mark_pol;
      line_out <= next_line;
      underrun <= next_underrun;
      // the switch is a pin, so it crosses in via two flops like the sync pin
      len_q1 <= line_len_bcd;
      shape_sel <= len_q1;
    end
  end

  // helper: cycles since last bit tick, for spacing check
  logic [7:0] gap;
  logic seen_tick;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      gap <= 8'h00;
      seen_tick <= 1'b0;
    end else if (ce) begin
      gap <= bit_tick ? 8'h00 : gap + 8'h01;
      seen_tick <= seen_tick || bit_tick;
    end
  end

  sequence sync_let_go;
    sync_release ##1 pending;
  endsequence

  sequence apply_tick;
    pending && tick_en;
  endsequence

  AST_BIT_SPACING: assert property (@(posedge core_clk) disable iff (reset)
    (tick_en && seen_tick) |-> (gap >= 8'(dsfsg_pkg::CYC_PER_BIT_MIN - 1)
      && gap <= 8'(dsfsg_pkg::CYC_PER_BIT_MAX - 1)))
    else $error("bit tick spacing off the line rate");

  AST_DATA_ON_TICK: assert property (@(posedge core_clk) disable iff (reset)
    $changed(line_out.data) |-> $past(tick_en))
    else $error("serial data changed between bit ticks");

  AST_AMI_SPLIT: assert property (@(posedge core_clk) disable iff (reset)
    (line_out.mark_pos || line_out.mark_neg) == line_out.data
      && !(line_out.mark_pos && line_out.mark_neg))
    else $error("ami marks do not match data");

  AST_AMI_ALTERNATE: assert property (@(posedge core_clk) disable iff (reset)
    ($past(tick_en) && line_out.data) |-> (line_out.mark_pos == !$past(mark_pol)))
    else $error("mark polarity did not alternate");

  AST_SYNC_CAPTURE: assert property (@(posedge core_clk) disable iff (reset || !ce)
    sync_release |-> sync_let_go)
    else $error("sync release not registered");

  AST_SYNC_REALIGN: assert property (@(posedge core_clk) disable iff (reset)
    apply_tick |=> (bit_cnt == dsfsg_pkg::BIT_CNT_RESET) && line_out.frame_start)
    else $error("frame not realigned on first bit tick after sync");

  AST_FRAME_LEN: assert property (@(posedge core_clk) disable iff (reset)
    (tick_en && !pending && bit_cnt != dsfsg_pkg::FRAME_LAST_BIT)
      |=> bit_cnt == $past(bit_cnt) + 8'h01)
    else $error("frame counter skipped");
endmodule : dsfsg_framer

// ===== dsfsg_line_model.sv
// line interface model: bcd switch source and ami mark checker
`timescale 1ns/1ps
module dsfsg_line_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // switch setting from the bench
  input wire logic [3:0] bcd_set,
  output logic [3:0] line_len_bcd,
  // stream from the framer
  input wire dsfsg_pkg::dsfsg_line_s line_out,
  output int ami_err
);
  logic last_neg;
  logic prev_pos;
  logic prev_neg;
  int run;
  // the switch is a static level, so it is passed straight through
  assign line_len_bcd = bcd_set;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      last_neg <= 1'b1;
      prev_pos <= 1'b0;
      prev_neg <= 1'b0;
      run <= 0;
      ami_err <= 0;
    end else begin
      prev_pos <= line_out.mark_pos;
      prev_neg <= line_out.mark_neg;
      // a mark held past one bit period hides two marks of one polarity
      run <= ((line_out.mark_pos && prev_pos) || (line_out.mark_neg && prev_neg)) ? run + 1 : 0;
      if (line_out.mark_pos && !prev_pos) last_neg <= 1'b0;
      if (line_out.mark_neg && !prev_neg) last_neg <= 1'b1;
      if ((line_out.mark_pos && line_out.mark_neg) || run > 131 ||
          (line_out.data !== (line_out.mark_pos | line_out.mark_neg)) ||
          (line_out.mark_pos && !prev_pos && !last_neg) ||
          (line_out.mark_neg && !prev_neg && last_neg)) ami_err <= ami_err + 1;
    end
  end
endmodule : dsfsg_line_model

// ===== testbench.sv
// self-checking bench for the ds1 framer
`timescale 1ns/1ps
module testbench;
  logic core_clk, reset, ce, in_valid, frame_bit, sync_pin, in_ready, underrun;
  logic [7:0] in_data;
  logic [3:0] bcd_set, line_len_bcd, shape_sel;
  dsfsg_pkg::dsfsg_line_s line_out;
  int n_fail, n_tests, cyc, ami_err;
  logic [7:0] bytes [4] = '{8'hA5, 8'h80, 8'hFF, 8'h01};
  dsfsg_framer u_dut (.core_clk(core_clk), .reset(reset), .ce(ce), .in_data(in_data),
    .in_valid(in_valid), .in_ready(in_ready), .frame_bit(frame_bit), .sync_pin(sync_pin),
    .line_len_bcd(line_len_bcd), .shape_sel(shape_sel), .line_out(line_out),
    .underrun(underrun));
  dsfsg_line_model u_line (.core_clk(core_clk), .reset(reset), .bcd_set(bcd_set),
    .line_len_bcd(line_len_bcd), .line_out(line_out), .ami_err(ami_err));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // one frame plus sync tests is about 26000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 40000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic t_reset();
    check("line_out", 8'h00, {4'h0, line_out});
    check("in_ready", 8'h01, {7'h00, in_ready});
    check("underrun", 8'h00, {7'h00, underrun});
    check("shape_sel", 8'h00, {4'h0, shape_sel});
    $display("test reset done");
  endtask : t_reset
  task automatic t_shape();
    bcd_set = 4'h9;
    step(2);
    check("shape_sel", 8'h09, {4'h0, shape_sel});
    bcd_set = 4'h3;
    step(2);
    check("shape_sel", 8'h03, {4'h0, shape_sel});
    $display("test shape done");
  endtask : t_shape
  task automatic t_sync_hold();
    logic seen;
    seen = 1'b0;
    step(300);
    sync_pin = 1'b1;
    repeat (300) begin
      step(1);
      seen |= line_out.frame_start;
    end
    check("frame_start while sync high", 8'h00, {7'h00, seen});
    $display("test sync hold done");
  endtask : t_sync_hold
  task automatic t_frame();
    int k, n, t0;
    logic exp, urun;
    frame_bit = 1'b1;
    sync_pin = 1'b0;
    n = 0;
    while (line_out.frame_start !== 1'b1 && n < 140) begin
      step(1);
      n++;
    end
    check("sync release to frame_start", 8'h01, {7'h00, n >= 4 && n <= 133});
    t0 = cyc;
    // fill the fifo until it refuses; the extra byte must never reach the line
    in_valid = 1'b1;
    for (k = 0; k < 4; k++) begin
      in_data = bytes[k];
      step(1);
    end
    in_data = 8'h3C;
    check("in_ready when full", 8'h00, {7'h00, in_ready});
    step(1);
    in_valid = 1'b0;
    // underrun pulses for one cycle, so it is gathered over each bit period
    urun = 1'b0;
    for (k = 0; k <= 193; k++) begin
      while (cyc < t0 + (k * 200000) / 1544 + 64) begin
        step(1);
        urun |= underrun;
      end
      exp = (k == 0) ? 1'b1 : (k >= 1 && k <= 32) ? bytes[(k-1)/8][7-((k-1)%8)] : 1'b0;
      check("data bit", {7'h00, exp}, {7'h00, line_out.data});
      check("frame_start", {7'h00, k % 193 == 0}, {7'h00, line_out.frame_start});
      check("underrun", {7'h00, k >= 33 && k <= 192 && (k - 1) % 8 == 0}, {7'h00, urun});
      urun = 1'b0;
      if (k == 1) frame_bit = 1'b0;
    end
    check("ami faults", 8'h00, {7'h00, ami_err != 0});
    $display("test frame done");
  endtask : t_frame
  task automatic t_freeze();
    dsfsg_pkg::dsfsg_line_s held;
    logic rdy;
    held = line_out;
    rdy = in_ready;
    // a free-running divider would end the framing bit well within this time
    ce = 1'b0;
    step(300);
    check("line_out frozen", {4'h0, held}, {4'h0, line_out});
    check("in_ready frozen", {7'h00, rdy}, {7'h00, in_ready});
    ce = 1'b1;
    $display("test freeze done");
  endtask : t_freeze
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    in_valid = 1'b0;
    in_data = 8'h00;
    frame_bit = 1'b0;
    sync_pin = 1'b0;
    bcd_set = 4'h0;
    step(2);
    reset = 1'b0;
    t_reset();
    t_shape();
    t_sync_hold();
    t_frame();
    t_freeze();
    report_and_stop();
  end
endmodule : testbench
